// [rtl/tmc_pkg.sv]
// Package with register map, field positions and carrier types of timer two
package tmc_pkg;

    localparam int          ADDR_W        = 9;
    localparam int          DATA_W        = 32;
    localparam int          IRQ_W         = 2;

    // Byte addresses of the register words
    localparam logic [8:0]  CTRL_OFFSET   = 9'h0c8;
    localparam logic [8:0]  STATUS_OFFSET = 9'h100;
    localparam logic [8:0]  MASK_OFFSET   = 9'h104;
    localparam logic [8:0]  MODE_OFFSET   = 9'h108;

    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic        MODE_RESET    = 1'b0;

    // Interrupt status and mask bit positions
    localparam int          IRQ_OVF_BIT   = 0;
    localparam int          IRQ_EXT_BIT   = 1;

    // Position of the down count enable in the mode word
    localparam int          MODE_DOWN_COUNT_ENABLE_BIT = 0;

    // Control register, bit 7 first
    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic counter_timer_select;
        logic capture_reload_select;
    } tmc_ctrl_type;

    // Strobes handed to the counter datapath and the serial port
    typedef struct packed {
        logic capture;
        logic reload;
        logic rx_baud_tick;
        logic tx_baud_tick;
    } tmc_strobe_type;

endpackage

// [rtl/tmc_fall_detect.sv]
// Falling edge detector for the external trigger pin
`timescale 1ns/1ps
module tmc_fall_detect
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output logic      fall
);

    logic pin_r;
    logic pin_nxt;

    always_comb
    begin
        pin_nxt = pin_in;
    end

    // Idles high so that a pin low straight out of reset counts as an edge
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pin_r <= 1'b1;
        else
            pin_r <= pin_nxt;
    end

    assign fall = pin_r & ~pin_in;

endmodule

// [rtl/tmc_timer_two.sv]
// Timer two control register, event flags, trigger qualifying and baud sources
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module tmc_timer_two
(
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic [tmc_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [tmc_pkg::DATA_W-1:0]    avs_writedata,
    input  wire logic [tmc_pkg::DATA_W/8-1:0]  avs_byteenable,
    output logic      [tmc_pkg::DATA_W-1:0]    avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          timer_overflow,
    input  wire logic                          timer_one_overflow,
    input  wire logic                          external_trigger_pin,
    output tmc_pkg::tmc_strobe_type            strobe,
    output logic                               run_control,
    output logic                               counter_timer_select,
    output logic                               down_count_enable,
    output logic                               irq
);

    tmc_pkg::tmc_ctrl_type           ctrl_r;
    tmc_pkg::tmc_ctrl_type           ctrl_nxt;
    logic [tmc_pkg::IRQ_W-1:0]       status_r;
    logic [tmc_pkg::IRQ_W-1:0]       status_nxt;
    logic [tmc_pkg::IRQ_W-1:0]       mask_r;
    logic [tmc_pkg::IRQ_W-1:0]       mask_nxt;
    logic                            down_count_enable_r;
    logic                            down_count_enable_nxt;
    logic                            ack_r;
    logic                            ack_nxt;
    logic [tmc_pkg::DATA_W-1:0]      rdata_r;
    logic [tmc_pkg::DATA_W-1:0]      rdata_nxt;

    logic                            trig_fall;
    logic                            serial_clocking;
    logic                            qual_edge;
    logic                            ovf_event;
    logic                            ext_event;
    logic                            wr_take;
    logic                            lane0;
    localparam int                   CTRL_W = $bits(tmc_pkg::tmc_ctrl_type);

    function automatic logic hit
    (
        input logic [tmc_pkg::ADDR_W-1:0] addr,
        input logic [tmc_pkg::ADDR_W-1:0] offset
    );
        hit = (addr == offset);
    endfunction

    tmc_fall_detect u_fall
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (external_trigger_pin),
        .fall    (trig_fall)
    );

    // Event qualifying and datapath strobes
    always_comb
    begin
        serial_clocking = ctrl_r.receive_clock_select
                        | ctrl_r.transmit_clock_select;
        qual_edge       = trig_fall
                        & ctrl_r.external_trigger_enable
                        & ~serial_clocking;
        ovf_event       = timer_overflow & ~serial_clocking;
        ext_event       = qual_edge;
        // Serial clocking forces reload on overflow, whatever the select bit
        strobe.capture  = qual_edge
                        & ctrl_r.capture_reload_select;
        strobe.reload   = (qual_edge & ~ctrl_r.capture_reload_select)
                        | (timer_overflow
                          & (serial_clocking
                            | ~ctrl_r.capture_reload_select));
        strobe.rx_baud_tick = ctrl_r.receive_clock_select
                            ? timer_overflow
                            : timer_one_overflow;
        strobe.tx_baud_tick = ctrl_r.transmit_clock_select
                            ? timer_overflow
                            : timer_one_overflow;
    end

    assign wr_take = avs_write & ack_r;
    assign lane0   = avs_byteenable[0];

    // Register next values; a hardware set wins over a software clear
    always_comb
    begin
        ctrl_nxt   = ctrl_r;
        status_nxt = status_r;
        mask_nxt   = mask_r;
        down_count_enable_nxt   = down_count_enable_r;
        if (wr_take && lane0)
        begin
            if (hit(avs_address, tmc_pkg::CTRL_OFFSET))
                ctrl_nxt = tmc_pkg::tmc_ctrl_type'(avs_writedata[7:0]);
            if (hit(avs_address, tmc_pkg::STATUS_OFFSET))
                status_nxt = status_r
                           & ~avs_writedata[tmc_pkg::IRQ_W-1:0];
            if (hit(avs_address, tmc_pkg::MASK_OFFSET))
                mask_nxt = avs_writedata[tmc_pkg::IRQ_W-1:0];
            if (hit(avs_address, tmc_pkg::MODE_OFFSET))
                down_count_enable_nxt = avs_writedata[tmc_pkg::MODE_DOWN_COUNT_ENABLE_BIT];
        end
        if (ovf_event)
        begin
            ctrl_nxt.overflow_flag = 1'b1;
            status_nxt[tmc_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (ext_event)
        begin
            ctrl_nxt.external_event_flag = 1'b1;
            // Up/down counting uses the edge for direction, not as an interrupt event
            if (!down_count_enable_r)
                status_nxt[tmc_pkg::IRQ_EXT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r   <= tmc_pkg::tmc_ctrl_type'(tmc_pkg::CTRL_RESET);
            status_r <= tmc_pkg::IRQ_RESET;
            mask_r   <= tmc_pkg::IRQ_RESET;
            down_count_enable_r   <= tmc_pkg::MODE_RESET;
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            down_count_enable_r   <= down_count_enable_nxt;
        end
    end

    // Bus answer: one wait state, read data captured before release
    always_comb
    begin
        ack_nxt   = (avs_read | avs_write) & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read && !ack_r)
        begin
            rdata_nxt = '0;
            if (hit(avs_address, tmc_pkg::CTRL_OFFSET))
                rdata_nxt[7:0] = ctrl_r;
            else if (hit(avs_address, tmc_pkg::STATUS_OFFSET))
                rdata_nxt[tmc_pkg::IRQ_W-1:0] = status_r;
            else if (hit(avs_address, tmc_pkg::MASK_OFFSET))
                rdata_nxt[tmc_pkg::IRQ_W-1:0] = mask_r;
            else if (hit(avs_address, tmc_pkg::MODE_OFFSET))
                rdata_nxt[tmc_pkg::MODE_DOWN_COUNT_ENABLE_BIT] = down_count_enable_r;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest      = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata         = rdata_r;
    assign run_control          = ctrl_r.run_control;
    assign counter_timer_select = ctrl_r.counter_timer_select;
    assign down_count_enable    = down_count_enable_r;
    // Level output; holds while any unmasked sticky bit is set
    assign irq                  = |(status_r & mask_r);

    chk_reset_clear:
    assert property (@(posedge clk_sys)
        $past(sys_rst) |-> (ctrl_r == tmc_pkg::CTRL_RESET))
    else $error("control register not zero after reset");

    chk_ovf_set:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        timer_overflow && !serial_clocking |=> ctrl_r.overflow_flag)
    else $error("overflow flag not set by overflow");

    chk_ovf_sticky:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_r.overflow_flag
        && !(wr_take && hit(avs_address, tmc_pkg::CTRL_OFFSET))
        |=> ctrl_r.overflow_flag)
    else $error("overflow flag cleared without software");

    chk_ovf_suppress:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        serial_clocking && !ctrl_r.overflow_flag && !wr_take
        |=> !ctrl_r.overflow_flag)
    else $error("overflow flag set while serial clocking");

    chk_ext_set:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (strobe.capture || strobe.reload) && trig_fall
        && ctrl_r.external_trigger_enable && !serial_clocking
        |=> ctrl_r.external_event_flag)
    else $error("external flag not set by trigger event");

    chk_ext_sticky:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_r.external_event_flag && !wr_take
        |=> ctrl_r.external_event_flag)
    else $error("external flag cleared by hardware");

    chk_irq_ext:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ext_event && !down_count_enable_r && mask_r[tmc_pkg::IRQ_EXT_BIT]
        ##1 !wr_take [*2] |-> irq)
    else $error("external event raised no interrupt");

    chk_irq_down_count_enable:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ext_event && down_count_enable_r && !status_r[tmc_pkg::IRQ_EXT_BIT]
        |=> !status_r[tmc_pkg::IRQ_EXT_BIT])
    else $error("external event counted in up/down mode");

    chk_rx_source:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        strobe.rx_baud_tick == (ctrl_r.receive_clock_select
                                ? timer_overflow : timer_one_overflow))
    else $error("receive baud source wrong");

    chk_tx_source:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        strobe.tx_baud_tick == (ctrl_r.transmit_clock_select
                                ? timer_overflow : timer_one_overflow))
    else $error("transmit baud source wrong");

    chk_trig_ignored:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl_r.external_trigger_enable && !timer_overflow
        |-> !strobe.capture && !strobe.reload)
    else $error("trigger acted while disabled");

    chk_serial_reload:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        serial_clocking |-> !strobe.capture
        && (strobe.reload == timer_overflow))
    else $error("trigger acted while clocking serial port");

    chk_bus_wait:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest
        ##1 (avs_read || avs_write) |-> !avs_waitrequest)
    else $error("bus answer later than one wait state");

    chk_status_ovf:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ovf_event |=> status_r[tmc_pkg::IRQ_OVF_BIT])
    else $error("overflow event not recorded in status");

    chk_status_ext:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ext_event && !down_count_enable_r |=> status_r[tmc_pkg::IRQ_EXT_BIT])
    else $error("external event not recorded in status");

    chk_status_w1c:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_take && lane0 && hit(avs_address, tmc_pkg::STATUS_OFFSET)
        && avs_writedata[tmc_pkg::IRQ_OVF_BIT] && !ovf_event
        |=> !status_r[tmc_pkg::IRQ_OVF_BIT])
    else $error("status bit not cleared by writing one");

    chk_irq_ext_level:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        status_r[tmc_pkg::IRQ_EXT_BIT] && mask_r[tmc_pkg::IRQ_EXT_BIT]
        |-> irq)
    else $error("pending external event not on interrupt");

    chk_reload_ovf:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        timer_overflow && !ctrl_r.capture_reload_select |-> strobe.reload)
    else $error("overflow gave no reload in reload mode");

    chk_capture_no_reload:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_r.capture_reload_select && !serial_clocking && !trig_fall
        |-> !strobe.reload)
    else $error("reload strobe in capture mode");

    chk_capture_edge:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        trig_fall && ctrl_r.external_trigger_enable && !serial_clocking
        && ctrl_r.capture_reload_select |-> strobe.capture)
    else $error("qualified edge gave no capture");

    chk_ext_disabled:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl_r.external_trigger_enable && !ctrl_r.external_event_flag
        && !wr_take |=> !ctrl_r.external_event_flag)
    else $error("external flag set while trigger disabled");

    chk_wait_first:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request answered without wait state");

    chk_read_ctrl:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        avs_read && !avs_waitrequest
        && hit(avs_address, tmc_pkg::CTRL_OFFSET)
        |-> avs_readdata[CTRL_W-1:0] == $past(ctrl_r)
            && avs_readdata[tmc_pkg::DATA_W-1:CTRL_W] == '0)
    else $error("control read data wrong");

    chk_read_unmapped:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        avs_read && !avs_waitrequest
        && !hit(avs_address, tmc_pkg::CTRL_OFFSET)
        && !hit(avs_address, tmc_pkg::STATUS_OFFSET)
        && !hit(avs_address, tmc_pkg::MASK_OFFSET)
        && !hit(avs_address, tmc_pkg::MODE_OFFSET)
        |-> avs_readdata == '0)
    else $error("unmapped read not zero");

    chk_mask_write:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_take && lane0 && hit(avs_address, tmc_pkg::MASK_OFFSET)
        |=> mask_r == $past(avs_writedata[tmc_pkg::IRQ_W-1:0]))
    else $error("mask write not taken");

    chk_lane_guard:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_take && !lane0 && !ovf_event && !ext_event |=> $stable(ctrl_r))
    else $error("control changed by write without low byte");

    chk_mode_write:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_take && lane0 && hit(avs_address, tmc_pkg::MODE_OFFSET)
        |=> down_count_enable
            == $past(avs_writedata[tmc_pkg::MODE_DOWN_COUNT_ENABLE_BIT]))
    else $error("mode write not taken");

endmodule

// [bench/tmc_far_end.sv]
// Far side model: timer datapaths, trigger pin and serial port counters
`timescale 1ns/1ps
module tmc_far_end
(
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    fire_two,
    input  wire logic                    fire_one,
    input  wire logic                    pin_lvl,
    input  wire tmc_pkg::tmc_strobe_type strobe,
    output logic                         timer_overflow,
    output logic                         timer_one_overflow,
    output logic                         external_trigger_pin,
    output logic [31:0]                  counts
);
    // Pulses last exactly the cycles the bench asks for
    assign timer_overflow       = fire_two;
    assign timer_one_overflow   = fire_one;
    assign external_trigger_pin = pin_lvl;

    // Bytes: receive ticks, transmit ticks, captures, reloads
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            counts <= 32'h0;
        else
            counts <= counts + {7'h00, strobe.rx_baud_tick,
                7'h00, strobe.tx_baud_tick, 7'h00, strobe.capture,
                7'h00, strobe.reload};
    end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the timer two control block
`timescale 1ns/1ps
module testbench;
    localparam logic [8:0] CT = tmc_pkg::CTRL_OFFSET;
    localparam logic [8:0] ST = tmc_pkg::STATUS_OFFSET;
    localparam logic [8:0] MK = tmc_pkg::MASK_OFFSET;
    localparam logic [8:0] MD = tmc_pkg::MODE_OFFSET;
    logic                    clk_sys, sys_rst, avs_read, avs_write;
    logic [8:0]              avs_address;
    logic [31:0]             avs_writedata, avs_readdata, counts, e_cnt, q;
    logic [3:0]              avs_byteenable;
    logic                    avs_waitrequest, fire_two, fire_one, pin_lvl;
    logic                    t2_ovf, t1_ovf, trig, run_control, irq;
    logic                    counter_timer_select, down_count_enable;
    tmc_pkg::tmc_strobe_type strobe;
    int                      n_fail, compares;

    tmc_timer_two i_tmc_timer_two (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_overflow(t2_ovf),
        .timer_one_overflow(t1_ovf), .external_trigger_pin(trig),
        .strobe(strobe), .run_control(run_control),
        .counter_timer_select(counter_timer_select),
        .down_count_enable(down_count_enable), .irq(irq));
    tmc_far_end i_tmc_far_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .fire_two(fire_two), .fire_one(fire_one), .pin_lvl(pin_lvl),
        .strobe(strobe), .timer_overflow(t2_ovf),
        .timer_one_overflow(t1_ovf), .external_trigger_pin(trig),
        .counts(counts));

    task automatic end_of_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waitrequest and read data are read at the rising edge, before that
    // edge updates them; one more edge passes so callers see settled outputs
    task automatic acc(input logic we, input logic [8:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 50)
            chk("waitrequest", 32'h0, 32'h1);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [8:0] a, input logic [31:0] e,
                      input string nm);
        acc(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    // 0: timer two overflow, 1: timer one overflow, 2: falling trigger
    task automatic ev(input int k, input logic [31:0] inc);
        @(posedge clk_sys);
        fire_two <= (k == 0);
        fire_one <= (k == 1);
        pin_lvl <= (k != 2);
        @(posedge clk_sys);
        {fire_two, fire_one} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        pin_lvl <= 1'b1;
        @(negedge clk_sys);
        e_cnt = e_cnt + inc;
        chk("counts", e_cnt, counts);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        #(50 * 20000);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        {sys_rst, pin_lvl} = 2'b11;
        {avs_read, avs_write, fire_two, fire_one} = 4'h0;
        {avs_address, avs_writedata, e_cnt} = '0;
        avs_byteenable = 4'hf;
        {n_fail, compares} = 0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(CT, 32'h0, "ctrl reset");
        rd(ST, 32'h0, "status reset");
        rd(MK, 32'h0, "mask reset");
        rd(MD, 32'h0, "mode reset");
        wr(9'h0cc, 32'hff);
        rd(9'h0cc, 32'h0, "unmapped");
        wr(CT, 32'h06);
        avs_byteenable <= 4'he;
        wr(CT, 32'h0);
        avs_byteenable <= 4'hf;
        rd(CT, 32'h06, "ctrl no byte0");
        chk("run", 32'h3, {run_control, counter_timer_select});
        wr(CT, 32'h0);
        wr(MK, 32'h3);
        ev(0, 32'h1);
        rd(CT, 32'h80, "overflow flag");
        chk("irq ovf", 32'h1, {31'h0, irq});
        wr(ST, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(CT, 32'h80, "overflow held");
        wr(CT, 32'h01);
        ev(0, 32'h0);
        rd(CT, 32'h81, "capture ovf");
        wr(CT, 32'h21);
        ev(0, 32'h01000001);
        ev(1, 32'h00010000);
        rd(CT, 32'h21, "no flag rclk");
        wr(CT, 32'h10);
        ev(0, 32'h00010001);
        ev(1, 32'h01000000);
        rd(CT, 32'h10, "no flag transmit_clock_select");
        wr(ST, 32'h3);
        wr(CT, 32'h09);
        ev(2, 32'h100);
        rd(CT, 32'h49, "event flag cap");
        chk("irq event", 32'h1, {31'h0, irq});
        rd(CT, 32'h49, "event held");
        wr(ST, 32'h2);
        chk("irq event clr", 32'h0, {31'h0, irq});
        wr(CT, 32'h08);
        ev(2, 32'h1);
        rd(CT, 32'h48, "event flag rel");
        wr(ST, 32'h2);
        wr(CT, 32'h01);
        ev(2, 32'h0);
        rd(CT, 32'h01, "trigger off");
        wr(CT, 32'h29);
        ev(2, 32'h0);
        rd(CT, 32'h29, "trigger serial");
        wr(MD, 32'h1);
        chk("down_count_enable", 32'h1, {31'h0, down_count_enable});
        wr(CT, 32'h09);
        ev(2, 32'h100);
        rd(ST, 32'h0, "status updown");
        chk("irq updown", 32'h0, {31'h0, irq});
        end_of_test();
    end
endmodule
